// ---- include/cfic_pkg.sv ----
// Register map, field layout and reset values of the filter and FIFO interrupt control block
package cfic_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] FILT_GRP2_OFF = 12'h000;
   localparam logic [11:0] FILT_GRP5_OFF = 12'h004;
   localparam logic [11:0] FIFO_INT_BASE = 12'h080;
   localparam int NUM_FIFO = 32;
   localparam int NUM_GRP = 2;
   localparam int LANES = 4;
   localparam int LANE_ON_BIT = 7;
   localparam int MASK_HI = 6;
   localparam int MASK_LO = 5;
   localparam int TGT_HI = 4;
   localparam int TGT_LO = 0;
   localparam int IEN_TX_LO = 24;
   localparam int IEN_RX_LO = 16;
   localparam int FLG_TX_LO = 8;
   localparam int FLG_RX_LO = 0;
   localparam int OVR_BIT = 3;
   localparam logic [31:0] FILT_RESET = 32'h0000_0000;
   localparam logic [6:0] IEN_RESET = 7'h00;
   localparam logic [31:0] FIFO_INT_RSVD = 32'hf8f0_f8f0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hw/cfic_ctrl.sv ----
// CAN acceptance filter control and per-FIFO interrupt registers behind an AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// How it works
// (RULE1) Disabled filters never accept a message
// (RULE2) Two-bit field picks one of four masks
// (RULE3) Accepted message goes to target FIFO number
// (RULE4) Fields writable only while filter is off
// (RULE5) Four filters per register, one per lane
// (RULE6) One interrupt register per FIFO, 0..31
// (RULE7) Fill-level flags read-only, follow FIFO state
// (RULE8) Transmit not-full flag zero in receive mode
// (RULE9) Overrun enable gates overrun interrupt request
// (RULE10) Request high when any enabled flag set
module cfic_ctrl
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] filter_hit,
   output logic accept_valid,
   output logic [4:0] accept_fifo,
   output logic [1:0] accept_mask,
   output logic [2:0] accept_filter,
   input wire logic [31:0] fifo_is_transmit,
   input wire logic [31:0] fifo_full,
   input wire logic [31:0] fifo_half,
   input wire logic [31:0] fifo_empty,
   input wire logic [31:0] fifo_overflow,
   output logic [31:0] fifo_irq
);
   logic aw_held, next_aw_held, w_held, next_w_held;
   logic [11:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_awready, next_wready, next_arready;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [31:0] fctl [cfic_pkg::NUM_GRP];
   logic [31:0] next_fctl [cfic_pkg::NUM_GRP];
   logic [6:0] ien [cfic_pkg::NUM_FIFO];
   logic [6:0] next_ien [cfic_pkg::NUM_FIFO];
   logic [31:0] ovr, next_ovr, next_irq;
   logic next_acc_valid;
   logic [4:0] next_acc_fifo;
   logic [1:0] next_acc_mask;
   logic [2:0] next_acc_filter;
   logic [7:0] fon, hit_en;
   logic wr_go;

   // Fields of a lane stay frozen while its enable is set; the enable itself stays writable
   function automatic logic [31:0] lane_write(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int l = 0; l < cfic_pkg::LANES; l++)
      begin
         if (strb[l])
         begin
            r[8*l+cfic_pkg::LANE_ON_BIT] = wd[8*l+cfic_pkg::LANE_ON_BIT];
            if (!old[8*l+cfic_pkg::LANE_ON_BIT])
               r[8*l +: 7] = wd[8*l +: 7]; // RULE4
         end
      end
      return r;
   endfunction

   // Flags: {tx_space, tx_half, tx_drained, rx_overrun, rx_packed, rx_half, rx_pending}
   function automatic logic [6:0] flags(input logic is_tx, input logic full, input logic half,
                                        input logic empty, input logic ov);
      flags = {is_tx & ~full, is_tx & half, is_tx & empty, // RULE7 RULE8
               ov, ~is_tx & full, ~is_tx & half, ~is_tx & ~empty};
   endfunction

   function automatic logic is_fifo_reg(input logic [11:0] a);
      is_fifo_reg = (a[11:7] == cfic_pkg::FIFO_INT_BASE[11:7]) && (a[1:0] == 2'h0);
   endfunction

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         fon[i] = fctl[i/4][8*(i%4)+cfic_pkg::LANE_ON_BIT];
      end
      hit_en = filter_hit & fon; // RULE1
   end

   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_comb
   begin
      logic [6:0] fl;
      logic [4:0] idx;
      fl = 7'h00;
      idx = 5'h00;
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      next_fctl = fctl;
      next_ien = ien;
      next_ovr = ovr;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      // Software may only clear the overrun flag by writing zero; clearing loses to a new event
      if (wr_go)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = cfic_pkg::RESP_OKAY;
         idx = aw_addr[6:2];
         if (aw_addr == cfic_pkg::FILT_GRP2_OFF)
            next_fctl[0] = lane_write(fctl[0], w_data, w_strb); // RULE5
         else if (aw_addr == cfic_pkg::FILT_GRP5_OFF)
            next_fctl[1] = lane_write(fctl[1], w_data, w_strb); // RULE5
         else if (is_fifo_reg(aw_addr))
         begin
            if (w_strb[3])
               next_ien[idx][6:4] = w_data[cfic_pkg::IEN_TX_LO +: 3]; // RULE6
            if (w_strb[2])
               next_ien[idx][3:0] = w_data[cfic_pkg::IEN_RX_LO +: 4];
            if (w_strb[0] && !w_data[cfic_pkg::OVR_BIT])
               next_ovr[idx] = 1'b0;
         end
         else
            next_bresp = cfic_pkg::RESP_SLVERR;
      end
      next_ovr = next_ovr | (fifo_overflow & ~fifo_is_transmit);
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid = 1'b1;
         next_rresp = cfic_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         idx = s_axi_araddr[6:2];
         fl = flags(fifo_is_transmit[idx], fifo_full[idx], fifo_half[idx], fifo_empty[idx], ovr[idx]);
         if (s_axi_araddr == cfic_pkg::FILT_GRP2_OFF)
            next_rdata = fctl[0];
         else if (s_axi_araddr == cfic_pkg::FILT_GRP5_OFF)
            next_rdata = fctl[1];
         else if (is_fifo_reg(s_axi_araddr))
            next_rdata = {5'h00, ien[idx][6:4], 4'h0, ien[idx][3:0],
                          5'h00, fl[6:4], 4'h0, fl[3:0]}; // RULE6 RULE7
         else
            next_rresp = cfic_pkg::RESP_SLVERR;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // Lowest-numbered enabled hit wins when several filters match at once
   always_comb
   begin
      logic [2:0] k;
      k = 3'h0;
      next_acc_valid = |hit_en; // RULE1
      next_acc_filter = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (hit_en[i])
            next_acc_filter = 3'(i);
      end
      k = next_acc_filter;
      next_acc_mask = fctl[k[2]][8*k[1:0]+cfic_pkg::MASK_LO +: 2]; // RULE2
      next_acc_fifo = fctl[k[2]][8*k[1:0]+cfic_pkg::TGT_LO +: 5]; // RULE3
   end

   always_comb
   begin
      for (int n = 0; n < cfic_pkg::NUM_FIFO; n++)
      begin
         next_irq[n] = |(ien[n] & flags(fifo_is_transmit[n], fifo_full[n], fifo_half[n],
                                        fifo_empty[n], ovr[n])); // RULE9 RULE10
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cfic_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= cfic_pkg::RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         for (int g = 0; g < cfic_pkg::NUM_GRP; g++)
            fctl[g] <= cfic_pkg::FILT_RESET;
         for (int n = 0; n < cfic_pkg::NUM_FIFO; n++)
            ien[n] <= cfic_pkg::IEN_RESET;
         ovr <= 32'h0000_0000;
         fifo_irq <= 32'h0000_0000;
         accept_valid <= 1'b0;
         accept_fifo <= 5'h00;
         accept_mask <= 2'h0;
         accept_filter <= 3'h0;
      end
      else
      begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_arready <= next_arready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         fctl <= next_fctl;
         ien <= next_ien;
         ovr <= next_ovr;
         fifo_irq <= next_irq;
         accept_valid <= next_acc_valid;
         accept_fifo <= next_acc_fifo;
         accept_mask <= next_acc_mask;
         accept_filter <= next_acc_filter;
      end
   end

   logic rd_f0, rd_g2, rd_fifo;
   assign rd_f0 = s_axi_arvalid && s_axi_arready && (s_axi_araddr == cfic_pkg::FIFO_INT_BASE);
   assign rd_g2 = s_axi_arvalid && s_axi_arready && (s_axi_araddr == cfic_pkg::FILT_GRP2_OFF);
   assign rd_fifo = s_axi_arvalid && s_axi_arready && is_fifo_reg(s_axi_araddr);

   sequence seq_only_f0_hit;
      hit_en == 8'h01;
   endsequence

   chk_disabled_no_accept: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
      accept_valid |-> $past(|(filter_hit & fon)))
      else $error("accept from a disabled filter");

   chk_mask_pick_lane: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      seq_only_f0_hit |=> accept_valid && (accept_mask == $past(fctl[0][6:5])))
      else $error("wrong mask choice on accept");

   chk_fifo_pick_lane: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
      seq_only_f0_hit |=> accept_filter == 3'h0 && (accept_fifo == $past(fctl[0][4:0])))
      else $error("wrong fifo target on accept");

   chk_locked_fields: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      $past(fctl[1][31]) |-> fctl[1][30:24] == $past(fctl[1][30:24]))
      else $error("fields changed while filter on");

   chk_group_readback: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      rd_g2 |=> s_axi_rvalid && (s_axi_rdata == $past(fctl[0])))
      else $error("filter group readback mismatch");

   chk_fifo_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
      rd_fifo |=> (s_axi_rdata & cfic_pkg::FIFO_INT_RSVD) == 32'h0000_0000)
      else $error("reserved fifo bits not zero");

   chk_pending_follows: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
      rd_f0 |=> s_axi_rdata[0] == $past(!fifo_is_transmit[0] && !fifo_empty[0]))
      else $error("pending flag does not follow fifo");

   chk_tx_space_mode: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
      rd_f0 |=> s_axi_rdata[10] == $past(fifo_is_transmit[0] && !fifo_full[0]))
      else $error("tx space flag wrong for mode");

   // With only the overrun enable set, the request must track the sticky overrun flag alone
   chk_overrun_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
      $past(ien[7] == 7'h08) |-> fifo_irq[7] == $past(ovr[7]))
      else $error("overrun enable does not gate request");

   chk_irq_source: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
      fifo_irq[0] |-> $past(|ien[0]) && ($past(ovr[0]) || $past(!fifo_empty[0] || fifo_is_transmit[0])))
      else $error("request with no enabled flag");
endmodule
`default_nettype wire

// ---- test/can_filter_fifo_interrupt_ctrl_bench.sv ----
// Self-checking bench for the filter control and FIFO interrupt block
`timescale 1ns/100ps
`default_nettype none
module can_filter_fifo_interrupt_ctrl_bench;
   localparam logic [1:0] OK = cfic_pkg::RESP_OKAY;
   localparam logic [1:0] ER = cfic_pkg::RESP_SLVERR;
   localparam logic [11:0] B = cfic_pkg::FIFO_INT_BASE;
   localparam logic [11:0] G2 = cfic_pkg::FILT_GRP2_OFF;
   localparam logic [11:0] G5 = cfic_pkg::FILT_GRP5_OFF;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot, accept_filter;
   logic [31:0] s_axi_wdata, s_axi_rdata, fifo_is_transmit, fifo_full, fifo_half, fifo_empty, fifo_overflow, fifo_irq;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, accept_mask;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, accept_valid;
   logic [7:0] filter_hit;
   logic [4:0] accept_fifo;
   logic [4:0] tg [4] = '{5'h00, 5'h01, 5'h1e, 5'h1f};
   int fail_count, checks_done, cycles;
   cfic_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .filter_hit, .accept_valid, .accept_fifo,
      .accept_mask, .accept_filter, .fifo_is_transmit, .fifo_full, .fifo_half, .fifo_empty,
      .fifo_overflow, .fifo_irq);
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard, far above the hundred-odd cycles the tests need
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fail_count++;
         stop_test();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa, pw, dn;
      pa = 1'b1;
      pw = 1'b1;
      dn = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!dn)
      begin
         @(posedge aclk);
         s_axi_awvalid <= pa && !s_axi_awready;
         pa = pa && !s_axi_awready;
         s_axi_wvalid <= pw && !s_axi_wready;
         pw = pw && !s_axi_wready;
         dn = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic pa, dn;
      pa = 1'b1;
      dn = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!dn)
      begin
         @(posedge aclk);
         s_axi_arvalid <= pa && !s_axi_arready;
         pa = pa && !s_axi_arready;
         dn = s_axi_rvalid;
      end
      s_axi_rready <= 1'b0;
      chk("rresp", 32'(s_axi_rresp), 32'(er));
      chk("rdata", s_axi_rdata, exp);
   endtask
   task automatic hit(input logic [7:0] h, input logic v, input logic [2:0] f, input logic [4:0] t);
      @(posedge aclk);
      filter_hit <= h;
      step(2);
      chk("accept_valid", 32'(accept_valid), 32'(v));
      if (v)
      begin
         chk("accept_filter", 32'(accept_filter), 32'(f));
         chk("accept_fifo", 32'(accept_fifo), 32'(t));
      end
   endtask
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {filter_hit, fifo_is_transmit, fifo_full, fifo_half, fifo_overflow} = '0;
      // Empty receive FIFOs keep every flag low, so reset reads come back zero
      fifo_empty = 32'hffff_ffff;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(G2, 32'h0, OK);
      rd(G5, 32'h0, OK);
      rd(B + 12'h07c, 32'h0, OK);
      rd(B, 32'h0, OK);
      rd(12'h040, 32'h0, ER);
      wr(12'h040, 32'hffff_ffff, ER);
      rd(G2, 32'h0, OK);
      wr(G2, 32'h7f5e_2100, OK);
      rd(G2, 32'h7f5e_2100, OK);
      wr(G2, 32'hffde_a180, OK);
      wr(G2, 32'h8080_8080, OK);
      rd(G2, 32'hffde_a180, OK);
      for (int i = 0; i < 4; i++)
      begin
         hit(8'(1 << i), 1'b1, 3'(i), tg[i]);
         chk("accept_mask", 32'(accept_mask), 32'(i));
      end
      // Disabling lane 3 while it is on must keep its fields
      wr(G2, 32'h00de_a180, OK);
      rd(G2, 32'h7fde_a180, OK);
      wr(G5, 32'h0000_009a, OK);
      hit(8'h18, 1'b1, 3'h4, 5'h1a);
      hit(8'h08, 1'b0, 3'h0, 5'h00);
      @(posedge aclk);
      fifo_is_transmit[5] <= 1'b1;
      fifo_empty[5] <= 1'b0;
      fifo_half[5] <= 1'b1;
      rd(B + 12'h014, 32'h0000_0600, OK);
      wr(B + 12'h014, 32'hffff_ffff, OK);
      rd(B + 12'h014, 32'h070f_0600, OK);
      step(2);
      chk("fifo_irq", fifo_irq, 32'h0000_0020);
      fifo_full[5] <= 1'b1;
      fifo_half[5] <= 1'b0;
      step(3);
      chk("fifo_irq", fifo_irq, 32'h0);
      fifo_is_transmit[5] <= 1'b0;
      rd(B + 12'h014, 32'h070f_0005, OK);
      @(posedge aclk);
      fifo_overflow <= 32'h80;
      @(posedge aclk);
      fifo_overflow <= 32'h0;
      rd(B + 12'h01c, 32'h0000_0008, OK);
      chk("fifo_irq", fifo_irq, 32'h0000_0020);
      wr(B + 12'h01c, 32'h0008_0008, OK);
      step(2);
      chk("fifo_irq", fifo_irq, 32'h0000_00a0);
      wr(B + 12'h01c, 32'h0008_0000, OK);
      rd(B + 12'h01c, 32'h0008_0000, OK);
      step(2);
      chk("fifo_irq", fifo_irq, 32'h0000_0020);
      stop_test();
   end
endmodule
`default_nettype wire
